// *** logic/led_target_port.sv ***
// Target end: serial port and register bank of a three-colour LED driver.
// Assumes link_clk runs free and far faster than the serial clock, so both
// lines are oversampled; the fault detectors drive fault_detect levels.
//
// Operation
// - Sample data while clock high, change low
// - Data change mid-transfer abandons the transfer
// - Start and stop are data edges, clock high
// - Controller owns start and stop; bus busy between
// - Repeated start acts as a first start
// - Bytes are eight bits, MSB first
// - Ninth pulse: transmitter releases, receiver pulls low
// - Addressed receiver acknowledges every byte
// - First byte is address 28h plus direction
// - Second byte selects register, third is data
// - Write takes effect at final acknowledge rise
// - Read returns register selected by earlier write
// - Three independent 10-bit current levels
// - Register 00h holds low level bits
// - Registers 01h-03h hold level bits 9:2
// - Bank also holds fault enable, delays, status
// - Fault enable gates pin; clearing clears status
// - Two-bit delay codes, default longest delay
// - Register 07h reports open/short flags, read-only
`timescale 1ns/1ps
module led_target_port (
  input  wire logic       link_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  led_i2c_if.device       bus,
  input  wire logic [5:0] fault_detect,
  output logic      [9:0] red_current_level,
  output logic      [9:0] green_current_level,
  output logic      [9:0] blue_current_level,
  output logic      [1:0] red_delay_code,
  output logic      [1:0] blue_delay_code,
  output logic      [1:0] green_delay_code,
  output logic            fault_report_enable,
  output logic            fault_out
);

  // ==========================================================================
  // State
  typedef enum logic [2:0] {
    P_IDLE   = 3'b000,
    P_RX     = 3'b001,
    P_ACK    = 3'b010,
    P_TX     = 3'b011,
    P_TX_ACK = 3'b100
  } phase_e;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_prev;
    logic       sda_prev;
    logic [5:0] fault_meta;
    logic [5:0] fault_in;
    phase_e     phase;
    logic [3:0] bit_cnt;
    logic [1:0] byte_no;
    logic       reading;
    logic [7:0] shift;
    logic [7:0] index;
    logic [7:0] wdata;
    logic       sda_oe;
    logic [7:0] low_bits;
    logic [7:0] green_high;
    logic [7:0] blue_high;
    logic [7:0] red_high;
    logic       fault_en;
    logic [7:0] delay_reg;
    logic [5:0] fault_status;
    logic       fault_pin;
  } dev_state_s;

  localparam dev_state_s DEV_RESET = '{
    phase:      P_IDLE,
    scl_sync:   2'h3,
    sda_sync:   2'h3,
    scl_prev:   1'b1,
    sda_prev:   1'b1,
    low_bits:   led_i2c_pkg::RST_LOW_BITS,
    green_high: led_i2c_pkg::RST_GREEN_HIGH,
    blue_high:  led_i2c_pkg::RST_BLUE_HIGH,
    red_high:   led_i2c_pkg::RST_RED_HIGH,
    fault_en:   led_i2c_pkg::RST_FAULT_EN,
    delay_reg:  led_i2c_pkg::RST_DELAY,
    default:    '0
  };

  dev_state_s s;
  dev_state_s next_s;

  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [7:0] rd;

  // ==========================================================================
  // Register read view; status order is green, blue, red open then short
  function automatic logic [7:0] read_reg(input dev_state_s st);
    logic [7:0] v;
    v = 8'h00;
    case (st.index)
      led_i2c_pkg::REG_LOW_BITS:     v = st.low_bits;
      led_i2c_pkg::REG_GREEN_HIGH:   v = st.green_high;
      led_i2c_pkg::REG_BLUE_HIGH:    v = st.blue_high;
      led_i2c_pkg::REG_RED_HIGH:     v = st.red_high;
      led_i2c_pkg::REG_FAULT_EN:     v = {7'h00, st.fault_en};
      led_i2c_pkg::REG_DELAY:        v = st.delay_reg;
      led_i2c_pkg::REG_FAULT_STATUS: v = {st.fault_status[5:4], 1'b0,
                                          st.fault_status[3:2], 1'b0,
                                          st.fault_status[1:0]};
      default:                       v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // ==========================================================================
  // Line events; only the second synchroniser stage and later are read
  assign scl        = s.scl_sync[1];
  assign sda        = s.sda_sync[1];
  assign scl_rise   = scl & ~s.scl_prev;
  assign scl_fall   = ~scl & s.scl_prev;
  assign start_seen = scl & s.scl_prev & s.sda_prev & ~sda;
  assign stop_seen  = scl & s.scl_prev & ~s.sda_prev & sda;
  assign rd         = read_reg(s);

  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.scl_sync   = {s.scl_sync[0], bus.scl};
      next_s.sda_sync   = {s.sda_sync[0], bus.sda};
      next_s.fault_meta = fault_detect;
      next_s.fault_in   = s.fault_meta;
      next_s.scl_prev   = scl;
      next_s.sda_prev   = sda;
      if (start_seen) begin
        // A start anywhere, even mid-byte, restarts address reception
        next_s.phase   = P_RX;
        next_s.bit_cnt = 4'h0;
        next_s.byte_no = 2'd0;
        next_s.reading = 1'b0;
        next_s.sda_oe  = 1'b0;
      end else if (stop_seen) begin
        // Any other data edge with the clock high is a stop: drop the transfer
        next_s.phase  = P_IDLE;
        next_s.sda_oe = 1'b0;
      end else begin
        unique case (s.phase)
          P_IDLE: begin
            next_s.sda_oe = 1'b0;
          end
          P_RX: begin
            if (scl_rise) begin
              next_s.shift   = {s.shift[6:0], sda};
              next_s.bit_cnt = s.bit_cnt + 4'h1;
            end else if (scl_fall && s.bit_cnt == led_i2c_pkg::BYTE_BITS) begin
              next_s.bit_cnt = 4'h0;
              next_s.phase   = P_ACK;
              next_s.sda_oe  = 1'b1;
              case (s.byte_no)
                2'd0: begin
                  if (s.shift[7:1] == led_i2c_pkg::TARGET_ADDR) begin
                    next_s.reading = s.shift[0];
                  end else begin
                    next_s.phase  = P_IDLE;
                    next_s.sda_oe = 1'b0;
                  end
                end
                2'd1:    next_s.index = s.shift;
                default: next_s.wdata = s.shift;
              endcase
            end
          end
          P_ACK: begin
            if (scl_rise && !s.reading && s.byte_no == 2'd2) begin
              case (s.index)
                led_i2c_pkg::REG_LOW_BITS:
                  next_s.low_bits = s.wdata & led_i2c_pkg::LOW_BITS_MASK;
                led_i2c_pkg::REG_GREEN_HIGH: next_s.green_high = s.wdata;
                led_i2c_pkg::REG_BLUE_HIGH:  next_s.blue_high = s.wdata;
                led_i2c_pkg::REG_RED_HIGH:   next_s.red_high = s.wdata;
                led_i2c_pkg::REG_FAULT_EN:
                  next_s.fault_en = s.wdata[led_i2c_pkg::FAULT_EN_POS];
                led_i2c_pkg::REG_DELAY:
                  next_s.delay_reg = s.wdata | led_i2c_pkg::DELAY_RSVD_ONES;
                default: next_s.wdata = s.wdata;
              endcase
            end else if (scl_fall) begin
              if (s.byte_no != 2'd2) begin
                next_s.byte_no = s.byte_no + 2'd1;
              end
              if (s.reading) begin
                next_s.phase  = P_TX;
                next_s.shift  = rd;
                next_s.sda_oe = ~rd[7];
              end else begin
                next_s.phase  = P_RX;
                next_s.sda_oe = 1'b0;
              end
            end
          end
          P_TX: begin
            if (scl_fall) begin
              if (s.bit_cnt == led_i2c_pkg::TX_LAST_BIT) begin
                next_s.phase   = P_TX_ACK;
                next_s.sda_oe  = 1'b0;
                next_s.bit_cnt = 4'h0;
              end else begin
                next_s.bit_cnt = s.bit_cnt + 4'h1;
                next_s.shift   = {s.shift[6:0], 1'b0};
                next_s.sda_oe  = ~s.shift[6];
              end
            end
          end
          P_TX_ACK: begin
            // An acknowledged byte is followed by a fresh read of the same index
            if (scl_rise) begin
              next_s.phase = sda ? P_IDLE : P_ACK;
            end
          end
          default: begin
            next_s.phase  = P_IDLE;
            next_s.sda_oe = 1'b0;
          end
        endcase
      end
      // Disabling reporting clears status and blocks new flags in that cycle
      if (!next_s.fault_en) begin
        next_s.fault_status = 6'h00;
      end else begin
        next_s.fault_status = s.fault_status | s.fault_in;
      end
      next_s.fault_pin = |next_s.fault_status;
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs: dev_sda_o is tied low, the rest taken directly from state
  assign bus.dev_sda_o         = 1'b0;
  assign bus.dev_sda_oe        = s.sda_oe;
  assign red_current_level     = {s.red_high, s.low_bits[led_i2c_pkg::RED_LOW_POS +: 2]};
  assign green_current_level   = {s.green_high, s.low_bits[led_i2c_pkg::GREEN_LOW_POS +: 2]};
  assign blue_current_level    = {s.blue_high, s.low_bits[led_i2c_pkg::BLUE_LOW_POS +: 2]};
  assign red_delay_code        = s.delay_reg[led_i2c_pkg::RED_DLY_POS +: 2];
  assign blue_delay_code       = s.delay_reg[led_i2c_pkg::BLUE_DLY_POS +: 2];
  assign green_delay_code      = s.delay_reg[led_i2c_pkg::GREEN_DLY_POS +: 2];
  assign fault_report_enable   = s.fault_en;
  assign fault_out             = s.fault_pin;

endmodule : led_target_port

// *** logic/led_i2c_pkg.sv ***
// Shared constants of the LED driver serial port: target address, register
// map, reset images, field positions and controller bit timing.
// Assumes both ends and the bench use every value through the package name.
package led_i2c_pkg;

  // ==========================================================================
  // Addressing and framing
  localparam logic [6:0] TARGET_ADDR   = 7'h28;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] TX_LAST_BIT   = 4'h7;

  // ==========================================================================
  // Register indices
  localparam logic [7:0] REG_LOW_BITS     = 8'h00;
  localparam logic [7:0] REG_GREEN_HIGH   = 8'h01;
  localparam logic [7:0] REG_BLUE_HIGH    = 8'h02;
  localparam logic [7:0] REG_RED_HIGH     = 8'h03;
  localparam logic [7:0] REG_FAULT_EN     = 8'h05;
  localparam logic [7:0] REG_DELAY        = 8'h06;
  localparam logic [7:0] REG_FAULT_STATUS = 8'h07;

  // ==========================================================================
  // Reset images, masks and field positions
  localparam logic [7:0] RST_LOW_BITS    = 8'h3f;
  localparam logic [7:0] RST_GREEN_HIGH  = 8'hff;
  localparam logic [7:0] RST_BLUE_HIGH   = 8'hff;
  localparam logic [7:0] RST_RED_HIGH    = 8'hff;
  localparam logic       RST_FAULT_EN    = 1'b1;
  localparam logic [7:0] RST_DELAY       = 8'hff;
  localparam logic [7:0] LOW_BITS_MASK   = 8'h3f;
  localparam logic [7:0] DELAY_RSVD_ONES = 8'h24;
  localparam int         RED_LOW_POS     = 4;
  localparam int         BLUE_LOW_POS    = 2;
  localparam int         GREEN_LOW_POS   = 0;
  localparam int         RED_DLY_POS     = 6;
  localparam int         BLUE_DLY_POS    = 3;
  localparam int         GREEN_DLY_POS   = 0;
  localparam int         FAULT_EN_POS    = 0;

  // ==========================================================================
  // Controller timing: one bit is four quarters, the clock high for two
  localparam int         SYS_CLK_PERIOD_NS  = 40;
  localparam int         SCL_QUARTER_NS     = 2500;
  localparam int         SCL_QUARTER_CYCLES =
    (SCL_QUARTER_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [7:0] QUARTER_LAST       = 8'(SCL_QUARTER_CYCLES - 1);

endpackage : led_i2c_pkg

// *** logic/led_i2c_if.sv ***
// Two-wire bus between the controller end and the LED driver target end.
// Assumes pull-ups: a line reads low only while some end enables a low drive.
`timescale 1ns/1ps
interface led_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // ==========================================================================
  // Wired-AND resolution of the open-drain lines
  assign scl = (host_scl_oe && !host_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o)) ? 1'b0 : 1'b1;

  modport host (
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input  scl, sda
  );
  modport device (
    output dev_sda_o, dev_sda_oe,
    input  scl, sda
  );
endinterface : led_i2c_if

// *** logic/led_bus_controller.sv ***
// Controller end: runs single register writes and reads on the two-wire bus.
// Assumes one target that never stretches the clock; the serial clock is
// made here from sys_clk by a quarter-bit divider.
`timescale 1ns/1ps
module led_bus_controller (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  led_i2c_if.host         bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_index,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            done,
  output logic            nack,
  output logic      [7:0] rdata
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BYTE  = 2'b10,
    H_STOP  = 2'b11
  } hphase_e;

  typedef struct packed {
    hphase_e    phase;
    logic [7:0] tick_cnt;
    logic [1:0] quarter;
    logic [3:0] bit_cnt;
    logic [1:0] byte_no;
    logic       restarted;
    logic       read_op;
    logic [7:0] index;
    logic [7:0] wdata;
    logic [7:0] shift;
    logic [1:0] sda_sync;
    logic       scl_oe;
    logic       sda_oe;
    logic       ready;
    logic       done;
    logic       nack;
    logic [7:0] rdata;
  } host_state_s;

  localparam host_state_s HOST_RESET = '{phase: H_IDLE, ready: 1'b1, default: '0};

  host_state_s s;
  host_state_s next_s;
  logic        tick;
  logic        rx;
  logic        sda;

  function automatic logic [7:0] tx_byte(input logic [1:0] num, input logic rs,
                                         input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] v;
    v = wd;
    if (num == 2'd0) begin
      v = {led_i2c_pkg::TARGET_ADDR, rs};
    end else if (num == 2'd1) begin
      v = idx;
    end
    return v;
  endfunction : tx_byte

  assign tick = (s.phase != H_IDLE) && (s.tick_cnt == led_i2c_pkg::QUARTER_LAST);
  assign rx   = s.read_op && s.restarted && (s.byte_no == 2'd1);
  assign sda  = s.sda_sync[1];

  // ==========================================================================
  // Bit engine: quarter 0 sets data, 1 raises clock, 2 samples, 3 lowers it
  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.sda_sync = {s.sda_sync[0], bus.sda};
      next_s.done     = 1'b0;
      if (s.phase != H_IDLE) begin
        next_s.tick_cnt = tick ? 8'h00 : s.tick_cnt + 8'h01;
      end
      if (s.phase == H_IDLE) begin
        if (cmd_valid && s.ready) begin
          next_s.phase     = H_START;
          next_s.ready     = 1'b0;
          next_s.read_op   = cmd_read;
          next_s.index     = cmd_index;
          next_s.wdata     = cmd_wdata;
          next_s.nack      = 1'b0;
          next_s.restarted = 1'b0;
          next_s.byte_no   = 2'd0;
          next_s.quarter   = 2'd0;
          next_s.tick_cnt  = 8'h00;
        end
      end else if (tick) begin
        next_s.quarter = s.quarter + 2'd1;
        unique case (s.phase)
          H_START: begin
            unique case (s.quarter)
              2'd0: next_s.sda_oe = 1'b0;
              2'd1: next_s.scl_oe = 1'b0;
              2'd2: next_s.sda_oe = 1'b1;
              2'd3: begin
                next_s.scl_oe  = 1'b1;
                next_s.phase   = H_BYTE;
                next_s.bit_cnt = 4'h0;
                next_s.shift   = tx_byte(s.byte_no, s.restarted, s.index, s.wdata);
              end
            endcase
          end
          H_BYTE: begin
            unique case (s.quarter)
              2'd0: begin
                // Released on the ninth pulse when sending, and after the
                // single read byte, which is the closing not-acknowledge
                next_s.sda_oe = !rx && (s.bit_cnt != led_i2c_pkg::BYTE_BITS)
                                && !s.shift[7];
              end
              2'd1: next_s.scl_oe = 1'b0;
              2'd2: begin
                if (s.bit_cnt != led_i2c_pkg::BYTE_BITS) begin
                  if (rx) begin
                    next_s.shift = {s.shift[6:0], sda};
                  end
                end else if (!rx) begin
                  next_s.nack = sda;
                end
              end
              2'd3: begin
                next_s.scl_oe = 1'b1;
                if (s.bit_cnt != led_i2c_pkg::BYTE_BITS) begin
                  next_s.bit_cnt = s.bit_cnt + 4'h1;
                  if (!rx) begin
                    next_s.shift = {s.shift[6:0], 1'b0};
                  end
                end else begin
                  next_s.bit_cnt = 4'h0;
                  if (s.nack || rx || (!s.read_op && s.byte_no == 2'd2)) begin
                    next_s.phase = H_STOP;
                    if (rx) begin
                      next_s.rdata = s.shift;
                    end
                  end else if (s.read_op && !s.restarted && s.byte_no == 2'd1) begin
                    next_s.phase     = H_START;
                    next_s.restarted = 1'b1;
                    next_s.byte_no   = 2'd0;
                  end else begin
                    next_s.byte_no = s.byte_no + 2'd1;
                    next_s.shift   = tx_byte(s.byte_no + 2'd1, s.restarted, s.index, s.wdata);
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (s.quarter)
              2'd0: next_s.sda_oe = 1'b1;
              2'd1: next_s.scl_oe = 1'b0;
              2'd2: next_s.sda_oe = 1'b0;
              2'd3: begin
                next_s.phase = H_IDLE;
                next_s.ready = 1'b1;
                next_s.done  = 1'b1;
              end
            endcase
          end
          default: next_s.phase = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= HOST_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = s.scl_oe;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = s.sda_oe;
  assign cmd_ready       = s.ready;
  assign done            = s.done;
  assign nack            = s.nack;
  assign rdata           = s.rdata;

endmodule : led_bus_controller

// *** tb/led_i2c_asserts.sv ***
// Checker for the two-wire link between the controller end and the target end.
// Assumes plain copies of the interface lines, both clocks and the shared reset.
`timescale 1ns/1ps
module led_i2c_asserts (
  input wire logic sys_clk,
  input wire logic link_clk,
  input wire logic rst,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================================
  // Frame tracker, sampled on sys_clk since the serial clock is made there
  typedef struct packed {
    logic       p_scl;
    logic       p_sda;
    logic       busy;
    logic       wr_ok;
    logic [3:0] bits;
    logic [1:0] bytes;
    logic [7:0] shreg;
  } mon_s;
  mon_s st;
  mon_s next_st;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic ninth_c;
  logic addr_hit;
  assign start_c  = st.p_scl && scl && st.p_sda && !sda;
  assign stop_c   = st.p_scl && scl && !st.p_sda && sda;
  assign rise_c   = !st.p_scl && scl;
  assign ninth_c  = rise_c && (st.bits == 4'h8);
  assign addr_hit = (st.shreg[7:1] == led_i2c_pkg::TARGET_ADDR);
  always_comb begin
    next_st = st;
    next_st.p_scl = scl;
    next_st.p_sda = sda;
    if (start_c) begin
      next_st.busy = 1'b1;
      next_st.bits = 4'h0;
      next_st.bytes = 2'h0;
      next_st.wr_ok = 1'b0;
    end else if (stop_c) begin
      next_st.busy = 1'b0;
    end else if (ninth_c) begin
      next_st.bits = 4'h0;
      if (st.bytes == 2'h0) next_st.wr_ok = addr_hit && !st.shreg[0];
      if (st.bytes != 2'h3) next_st.bytes = st.bytes + 2'h1;
    end else if (rise_c) begin
      next_st.shreg = {st.shreg[6:0], sda};
      next_st.bits = st.bits + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    // Idle lines are high, so the edge detectors start high: no false edge
    if (rst) st <= '{p_scl: 1'b1, p_sda: 1'b1, default: '0};
    else st <= next_st;
  end

  // ==========================================================================
  // Assertions
  a_dev_holds_high:
  assert property (@(posedge link_clk) disable iff (rst) scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("target data moved while clock high");
  a_scl_high_min:
  assert property (@(posedge sys_clk) disable iff (rst) $fell(host_scl_oe) |-> !host_scl_oe[*8])
    else $error("serial clock high phase too short");
  a_start_then_low:
  assert property (@(posedge sys_clk) disable iff (rst)
    $rose(host_sda_oe) && scl |-> ##[1:130] !scl) else $error("no clock low after start");
  a_addr_ack:
  assert property (@(posedge sys_clk) disable iff (rst)
    ninth_c && st.bytes == 2'h0 && addr_hit |-> !sda) else $error("address not acknowledged");
  a_write_ack:
  assert property (@(posedge sys_clk) disable iff (rst)
    ninth_c && st.bytes != 2'h0 && st.wr_ok |-> !sda) else $error("write byte not acknowledged");
  a_drive_after_fall:
  assert property (@(posedge sys_clk) disable iff (rst) $rose(dev_sda_oe) |-> !scl[*8])
    else $error("target drove data outside clock low");
  a_ack_slot:
  assert property (@(posedge sys_clk) disable iff (rst)
    $rose(dev_sda_oe) && (st.bytes == 2'h0 || st.wr_ok) |-> st.bits == 4'h8)
    else $error("acknowledge not after eighth bit");
  a_idle_quiet:
  assert property (@(posedge sys_clk) disable iff (rst) !st.busy |-> !dev_sda_oe)
    else $error("target drove data on a free bus");
endmodule : led_i2c_asserts

// *** tb/led_driver_serial_register_port_test.sv ***
// Bench: controller end and target end joined by the bus, driven by commands.
// Assumes the package constants and the designer's command handshake.
`timescale 1ns/1ps
module led_driver_serial_register_port_test;
  logic       sys_clk, link_clk, rst, cmd_valid, cmd_read;
  logic       cmd_ready, done, nack, fault_report_enable, fault_out;
  logic [7:0] cmd_index, cmd_wdata, rdata;
  logic [5:0] fault_detect;
  logic [9:0] red_current_level, green_current_level, blue_current_level;
  logic [1:0] red_delay_code, blue_delay_code, green_delay_code;
  int         err_count, n_checks;

  led_i2c_if u_led_i2c_if ();
  led_target_port u_led_target_port (.link_clk(link_clk), .rst(rst), .ce(1'b1),
    .bus(u_led_i2c_if), .fault_detect(fault_detect), .red_current_level(red_current_level),
    .green_current_level(green_current_level), .blue_current_level(blue_current_level),
    .red_delay_code(red_delay_code), .blue_delay_code(blue_delay_code),
    .green_delay_code(green_delay_code), .fault_report_enable(fault_report_enable),
    .fault_out(fault_out));
  led_bus_controller u_led_bus_controller (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
    .bus(u_led_i2c_if), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_index(cmd_index),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done), .nack(nack), .rdata(rdata));
  led_i2c_asserts u_led_i2c_asserts (.sys_clk(sys_clk), .link_clk(link_clk), .rst(rst),
    .host_scl_oe(u_led_i2c_if.host_scl_oe), .host_sda_oe(u_led_i2c_if.host_sda_oe),
    .dev_sda_oe(u_led_i2c_if.dev_sda_oe), .scl(u_led_i2c_if.scl), .sda(u_led_i2c_if.sda));

  // ==========================================================================
  // Clocks: link clock offset so its edges never line up with sys_clk
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string nm, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge sys_clk);
    #2;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_index = idx;
    cmd_wdata = wd;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    // Ready is settled high here, so the request is taken at the next edge
    @(posedge sys_clk);
    #2;
    cmd_valid = 1'b0;
    check("ready low", 10'h0, {9'h0, cmd_ready});
    // A read is about 9830 cycles, so the bound leaves some slack
    n = 0;
    while (done !== 1'b1 && n < 12000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    check("done", 10'h1, {9'h0, done});
    check("nack", 10'h0, {9'h0, nack});
  endtask : xfer
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check("red level", 10'h3ff, red_current_level);
    check("green level", 10'h3ff, green_current_level);
    check("blue level", 10'h3ff, blue_current_level);
    check("delays", 10'h3f, {4'h0, red_delay_code, blue_delay_code, green_delay_code});
    check("fault enable", 10'h1, {9'h0, fault_report_enable});
    $display("test reset done");
  endtask : t_reset
  task automatic t_levels;
    xfer(1'b0, led_i2c_pkg::REG_RED_HIGH, 8'ha5);
    xfer(1'b0, led_i2c_pkg::REG_LOW_BITS, 8'he6);
    check("red level", 10'h296, red_current_level);
    check("blue level", 10'h3fd, blue_current_level);
    check("green level", 10'h3fe, green_current_level);
    xfer(1'b0, led_i2c_pkg::REG_DELAY, 8'h4a);
    check("delay codes", 10'h16, {4'h0, red_delay_code, blue_delay_code, green_delay_code});
    xfer(1'b1, led_i2c_pkg::REG_LOW_BITS, 8'h00);
    check("low bits read", 10'h026, {2'h0, rdata});
    $display("test levels done");
  endtask : t_levels
  task automatic t_unmapped;
    xfer(1'b0, 8'h04, 8'h55);
    xfer(1'b1, 8'h04, 8'h00);
    check("unmapped read", 10'h000, {2'h0, rdata});
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic t_fault;
    fault_detect = 6'b100001;
    repeat (10) @(posedge sys_clk);
    #2;
    check("fault pin set", 10'h1, {9'h0, fault_out});
    xfer(1'b0, led_i2c_pkg::REG_FAULT_STATUS, 8'hff);
    xfer(1'b1, led_i2c_pkg::REG_FAULT_STATUS, 8'h00);
    check("fault status", 10'h081, {2'h0, rdata});
    xfer(1'b0, led_i2c_pkg::REG_FAULT_EN, 8'h00);
    check("fault pin cleared", 10'h0, {9'h0, fault_out});
    check("fault enable off", 10'h0, {9'h0, fault_report_enable});
    $display("test fault done");
  endtask : t_fault

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_index = 8'h00;
    cmd_wdata = 8'h00;
    fault_detect = 6'h00;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    t_reset();
    t_levels();
    t_unmapped();
    t_fault();
    final_report();
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    final_report();
  end
endmodule : led_driver_serial_register_port_test
